// [logic/spu_serial_port.sv]
// Four-mode serial port with APB register access
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module spu_serial_port
    import spu_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Baud sources
    input  wire logic        t1_ovf,
    input  wire logic        t2_ovf,
    // Serial pins
    input  wire logic        serial_data_pin_i,
    output logic             serial_data_pin_o,
    output logic             serial_data_pin_oe_n,
    output logic             serial_out_pin,
    // Port request to interrupt controller
    output logic             port_irq
);
    typedef struct packed {
        logic [7:0]  ctrl;       // port_control_reg minus bit 7
        logic        mode_hi;    // mode_select_high_bit
        logic        fe;         // frame_error_flag
        logic [7:0]  cfg;
        logic        fesel;      // frame_error_select
        logic [7:0]  tx_buf;
        logic [7:0]  rx_buf;
        logic [9:0]  tsh;        // 8 data, ninth, stop; start bit comes from SPU_START
        logic [3:0]  tcnt;
        logic [3:0]  tdiv;
        logic        tpend;
        spu_state_t  tst;
        logic [8:0]  rsh;
        logic [3:0]  rcnt;
        logic [3:0]  rdiv;
        spu_state_t  rst;
        logic        line_q;
        logic [3:0]  m0div;
        logic        sclk;
        logic        m0_rx;
        logic [3:0]  m0cnt;
        logic        ovr;
    } spu_st_t;
    spu_st_t s_q, s_d;

    logic       rxd_s;
    logic       tick;
    logic [1:0] mode;
    logic       acc;

    // Word address match helper
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction : hit

    spu_sync u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .din     (serial_data_pin_i),
        .dout    (rxd_s)
    );

    spu_tick_gen u_tick (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .mode        (mode),
        .timer_sel   (s_q.cfg[SPU_G_TSEL]),
        .m2_div_sel  (s_q.cfg[SPU_G_M2LO +: 2]),
        .t1_ovf      (t1_ovf),
        .t2_ovf      (t2_ovf),
        .sample_tick (tick)
    );

    assign mode = {s_q.mode_hi, s_q.ctrl[SPU_C_MODELO]};
    assign acc  = psel & penable;

    // Zero-wait slave; unmapped addresses read zero and flag an error
    assign pready  = 1'b1;
    assign pslverr = acc & ~(hit(paddr, SPU_CTRL_OFF) | hit(paddr, SPU_BUF_OFF) |
                             hit(paddr, SPU_CFG_OFF) | hit(paddr, SPU_PWR_OFF) |
                             hit(paddr, SPU_STAT_OFF));

    // Read mux
    always_comb begin
        prdata = 32'h0000_0000;
        if (hit(paddr, SPU_CTRL_OFF)) begin
            prdata[7:0] = {s_q.fesel ? s_q.fe : s_q.mode_hi, s_q.ctrl[6:0]};
        end else if (hit(paddr, SPU_BUF_OFF)) begin
            prdata[7:0] = s_q.rx_buf;
        end else if (hit(paddr, SPU_CFG_OFF)) begin
            prdata[7:0] = s_q.cfg;
        end else if (hit(paddr, SPU_PWR_OFF)) begin
            prdata[SPU_P_FESEL] = s_q.fesel;
        end else if (hit(paddr, SPU_STAT_OFF)) begin
            prdata[3:0] = {s_q.ovr, s_q.m0_rx, s_q.rst != SPU_IDLE, s_q.tst != SPU_IDLE};
        end
    end

    // Next-state logic of the whole port
    always_comb begin
        logic set_ti;
        logic set_ri;
        logic set_fe;
        logic wr_buf;
        logic m0_rise;
        logic m0_fall;
        logic ninth;
        logic [3:0] lim;
        set_ti  = 1'b0;
        set_ri  = 1'b0;
        set_fe  = 1'b0;
        m0_rise = 1'b0;
        m0_fall = 1'b0;
        ninth   = 1'b0;
        s_d     = s_q;
        wr_buf  = acc & pwrite & hit(paddr, SPU_BUF_OFF);
        if (tick) s_d.line_q = rxd_s;

        // Mode 0 shift clock: half period of 6 or 1 system clocks
        lim = s_q.cfg[SPU_G_FAST] ? 4'(SPU_M0_FAST_DIV / 2 - 1) : 4'(SPU_M0_SLOW_DIV / 2 - 1);
        if (mode == 2'd0 && (s_q.tst == SPU_DATA || s_q.m0_rx)) begin
            if (s_q.m0div >= lim) begin
                s_d.m0div = 4'd0;
                s_d.sclk  = ~s_q.sclk;
                m0_rise   = ~s_q.sclk;
                m0_fall   = s_q.sclk;
            end else begin
                s_d.m0div = s_q.m0div + 4'd1;
            end
        end else begin
            s_d.m0div = 4'd0;
            s_d.sclk  = 1'b1;
        end

        // Transmit engine
        if (wr_buf) begin
            s_d.tx_buf = pwdata[7:0];
            s_d.tsh    = {1'b1, s_q.ctrl[SPU_C_TX9], pwdata[7:0]};
            s_d.tcnt   = 4'd0;
            s_d.tdiv   = 4'd0;
            if (mode == 2'd0) begin
                s_d.tst = SPU_DATA;
            end else begin
                s_d.tpend = 1'b1;
                s_d.tst   = SPU_IDLE;
            end
        end else begin
            case (s_q.tst)
                SPU_IDLE: begin
                    if (s_q.tpend && tick) begin
                        s_d.tpend = 1'b0;
                        s_d.tst   = SPU_START;
                    end
                end
                SPU_START: begin
                    if (tick) begin
                        s_d.tdiv = s_q.tdiv + 4'd1;
                        if (s_q.tdiv == 4'(SPU_OVS - 1)) begin
                            s_d.tst = SPU_DATA;
                        end
                    end
                end
                SPU_DATA: begin
                    if (mode == 2'd0) begin
                        // No shift before the first rise, else bit 0 is never seen
                        if (m0_fall && s_q.tcnt != 4'd0) begin
                            s_d.tsh = {1'b1, s_q.tsh[9:1]};
                        end
                        if (m0_rise) begin
                            s_d.tcnt = s_q.tcnt + 4'd1;
                            if (s_q.tcnt == 4'd7) begin
                                s_d.tst = SPU_IDLE;
                                set_ti  = 1'b1;
                            end
                        end
                    end else if (tick) begin
                        s_d.tdiv = s_q.tdiv + 4'd1;
                        if (s_q.tdiv == 4'(SPU_OVS - 1)) begin
                            s_d.tsh  = {1'b1, s_q.tsh[9:1]};
                            s_d.tcnt = s_q.tcnt + 4'd1;
                            if (s_q.tcnt == ((mode == 2'd1) ? 4'd7 : 4'd8)) begin
                                set_ti  = 1'b1;
                                s_d.tst = SPU_STOP;
                            end
                        end
                    end
                end
                SPU_STOP: begin
                    if (tick) begin
                        s_d.tdiv = s_q.tdiv + 4'd1;
                        if (s_q.tdiv == 4'(SPU_OVS - 1)) begin
                            s_d.tst = SPU_IDLE;
                        end
                    end
                end
                default: s_d.tst = SPU_IDLE;
            endcase
        end

        // Mode 0 receive: preload marker pattern, shift on falling edges
        if (mode == 2'd0) begin
            if (!s_q.m0_rx && s_q.tst == SPU_IDLE && s_q.ctrl[SPU_C_RXEN] && !s_q.ctrl[SPU_C_RXDONE] && !wr_buf) begin
                s_d.rsh   = 9'b111111110;
                s_d.m0_rx = 1'b1;
                s_d.m0cnt = 4'd0;
            end else if (s_q.m0_rx && m0_fall) begin
                s_d.rsh   = {rxd_s, s_q.rsh[8:1]};
                s_d.m0cnt = s_q.m0cnt + 4'd1;
                if (s_q.m0cnt == 4'd7) begin
                    s_d.m0_rx  = 1'b0;
                    s_d.rx_buf = {rxd_s, s_q.rsh[8:2]};
                    set_ri     = 1'b1;
                end
            end
            s_d.rst = SPU_IDLE;
        end else begin
            s_d.m0_rx = 1'b0;
            case (s_q.rst)
                SPU_IDLE: begin
                    if (tick && s_q.line_q && !rxd_s && s_q.ctrl[SPU_C_RXEN]) begin
                        s_d.rst  = SPU_START;
                        s_d.rdiv = 4'd0;
                        s_d.rcnt = 4'd0;
                    end
                end
                SPU_START: begin
                    if (tick) begin
                        s_d.rdiv = s_q.rdiv + 4'd1;
                        if (s_q.rdiv == 4'(SPU_OVS / 2 - 1)) begin
                            // False start rejected at bit centre
                            s_d.rst  = rxd_s ? SPU_IDLE : SPU_DATA;
                            s_d.rdiv = 4'd0;
                        end
                    end
                end
                SPU_DATA: begin
                    if (tick) begin
                        s_d.rdiv = s_q.rdiv + 4'd1;
                        if (s_q.rdiv == 4'(SPU_OVS - 1)) begin
                            s_d.rsh  = {rxd_s, s_q.rsh[8:1]};
                            s_d.rcnt = s_q.rcnt + 4'd1;
                            if (s_q.rcnt == ((mode == 2'd1) ? 4'd7 : 4'd8)) begin
                                s_d.rst = SPU_STOP;
                            end
                        end
                    end
                end
                SPU_STOP: begin
                    if (tick) begin
                        s_d.rdiv = s_q.rdiv + 4'd1;
                        if (s_q.rdiv == 4'(SPU_OVS - 1)) begin
                            s_d.rst = SPU_IDLE;
                            set_fe  = ~rxd_s;
                            ninth   = (mode == 2'd1) ? rxd_s : s_q.rsh[8];
                            if (!s_q.ctrl[SPU_C_MPEN] || ((mode == 2'd1) ? rxd_s : ninth)) begin
                                set_ri = 1'b1;
                                s_d.ovr = s_q.ctrl[SPU_C_RXDONE];
                                s_d.rx_buf = (mode == 2'd1) ? s_q.rsh[8:1] : s_q.rsh[7:0];
                                s_d.ctrl[SPU_C_RX9] = ninth;
                            end
                        end
                    end
                end
                default: s_d.rst = SPU_IDLE;
            endcase
        end

        // Software writes, hardware sets win after
        if (acc && pwrite && hit(paddr, SPU_CTRL_OFF)) begin
            s_d.ctrl = pwdata[7:0];
            if (s_q.fesel) begin
                s_d.fe = pwdata[SPU_C_BIT7];
            end else begin
                s_d.mode_hi = pwdata[SPU_C_BIT7];
            end
        end
        if (acc && pwrite && hit(paddr, SPU_CFG_OFF)) begin
            s_d.cfg = pwdata[7:0];
        end
        if (acc && pwrite && hit(paddr, SPU_PWR_OFF)) begin
            s_d.fesel = pwdata[SPU_P_FESEL];
        end
        if (set_ti) begin
            s_d.ctrl[SPU_C_TXDONE] = 1'b1;
        end
        if (set_ri) begin
            s_d.ctrl[SPU_C_RXDONE] = 1'b1;
        end
        if (set_fe) begin
            s_d.fe = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_q        <= '0;
            s_q.ctrl   <= SPU_CTRL_RST;
            s_q.cfg    <= SPU_CFG_RST;
            s_q.tsh    <= '1;
            s_q.tst    <= SPU_IDLE;
            s_q.rst    <= SPU_IDLE;
            s_q.line_q <= 1'b1;
            s_q.sclk   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Pin drive: mode 0 data on the data pin, clock on the out pin
    always_comb begin
        if (mode == 2'd0) begin
            serial_data_pin_o    = s_q.tsh[0];
            serial_data_pin_oe_n = ~(s_q.tst == SPU_DATA);
            serial_out_pin       = s_q.sclk;
        end else begin
            serial_data_pin_o    = 1'b1;
            serial_data_pin_oe_n = 1'b1;
            case (s_q.tst)
                SPU_START: serial_out_pin = 1'b0;
                SPU_DATA:  serial_out_pin = s_q.tsh[0];
                default:   serial_out_pin = 1'b1;
            endcase
        end
    end

    assign port_irq = s_q.ctrl[SPU_C_TXDONE] | s_q.ctrl[SPU_C_RXDONE];
endmodule : spu_serial_port
`default_nettype wire

// [inc/spu_pkg.sv]
// Package: register map, field positions, timing constants for the serial port
package spu_pkg;

    // Register byte offsets
    localparam logic [11:0] SPU_CTRL_OFF   = 12'h000;  // port_control_reg
    localparam logic [11:0] SPU_BUF_OFF    = 12'h004;  // port_buffer
    localparam logic [11:0] SPU_CFG_OFF    = 12'h008;  // port_config_reg
    localparam logic [11:0] SPU_PWR_OFF    = 12'h00c;  // power_control_reg
    localparam logic [11:0] SPU_STAT_OFF   = 12'h010;  // internal status

    // Control register field positions
    localparam int SPU_C_RXDONE   = 0;
    localparam int SPU_C_TXDONE   = 1;
    localparam int SPU_C_RX9      = 2;
    localparam int SPU_C_TX9      = 3;
    localparam int SPU_C_RXEN     = 4;
    localparam int SPU_C_MPEN     = 5;
    localparam int SPU_C_MODELO   = 6;
    localparam int SPU_C_BIT7     = 7;

    // Config register fields
    localparam int SPU_G_FAST     = 0;  // shift_clock_fast_select
    localparam int SPU_G_TSEL     = 1;  // 0: timer 1, 1: timer 2
    localparam int SPU_G_M2LO     = 2;  // mode 2 divider select, 2 bits
    // Power control field
    localparam int SPU_P_FESEL    = 6;  // frame_error_select

    // Reset values
    localparam logic [7:0] SPU_CTRL_RST = 8'h00;
    localparam logic [7:0] SPU_CFG_RST  = 8'h00;

    // Divider figures
    localparam int SPU_M0_SLOW_DIV = 12;
    localparam int SPU_M0_FAST_DIV = 2;
    localparam int SPU_OVS         = 16;  // receive sample ticks per bit

    // Shared state encodings
    typedef enum logic [3:0] {
        SPU_IDLE  = 4'b0001,
        SPU_START = 4'b0010,
        SPU_DATA  = 4'b0100,
        SPU_STOP  = 4'b1000
    } spu_state_t;

endpackage : spu_pkg

// [logic/spu_tick_gen.sv]
// Sample tick generator: system-clock dividers and timer overflow select
`timescale 1ns/1ps
`default_nettype none
module spu_tick_gen
    import spu_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Selection
    input  wire logic [1:0] mode,
    input  wire logic       timer_sel,
    input  wire logic [1:0] m2_div_sel,
    input  wire logic       t1_ovf,
    input  wire logic       t2_ovf,
    // Tick to serial engine (16x bit rate)
    output logic            sample_tick
);
    typedef struct packed {
        logic [1:0] cnt;
        logic       tick;
    } spu_tg_t;
    spu_tg_t s_q, s_d;

    // Mode 2 divides system clock by 1, 2 or 4 before the 16x sampler
    always_comb begin
        logic [1:0] lim;
        lim = 2'd0;
        s_d = s_q;
        case (m2_div_sel)
            2'd0:    lim = 2'd3;   // 1/64 bit rate
            2'd1:    lim = 2'd1;   // 1/32 bit rate
            default: lim = 2'd0;   // 1/16 bit rate
        endcase
        s_d.tick = 1'b0;
        if (mode == 2'd2) begin
            if (s_q.cnt >= lim) begin
                s_d.cnt  = 2'd0;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 2'd1;
            end
        end else begin
            s_d.cnt  = 2'd0;
            s_d.tick = timer_sel ? t2_ovf : t1_ovf;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sample_tick = s_q.tick;
endmodule : spu_tick_gen
`default_nettype wire

// [logic/spu_sync.sv]
// Two-flop synchroniser for a pin input
`timescale 1ns/1ps
`default_nettype none
module spu_sync (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    // Pin in, synchronised out
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } spu_sy_t;
    spu_sy_t s_q, s_d;

    // Idle line level is high
    always_comb begin
        s_d.s1 = din;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.s2;
endmodule : spu_sync
`default_nettype wire

// [tb/spu_port_monitor.sv]
// Port checker for the serial port
`timescale 1ns/1ps
`default_nettype none
module spu_port_monitor
    import spu_pkg::*;
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        reset,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and request
    input wire logic        serial_data_pin_oe_n,
    input wire logic        serial_out_pin,
    input wire logic        port_irq
);
    logic       acc, wr, mapped, m0, fast_q, fesel_q;
    logic [1:0] mode_q;

    // Access strobes and decode
    assign acc    = psel & penable;
    assign wr     = acc & pwrite & pready;
    assign mapped = paddr inside {SPU_CTRL_OFF, SPU_BUF_OFF, SPU_CFG_OFF, SPU_PWR_OFF, SPU_STAT_OFF};
    assign m0     = mode_q == 2'b00;

    // Mode mirror
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mode_q  <= 2'b00;
            fesel_q <= 1'b0;
            fast_q  <= 1'b0;
        end else if (wr) begin
            if (paddr == SPU_CTRL_OFF) mode_q <= {fesel_q ? mode_q[1] : pwdata[7], pwdata[6]};
            if (paddr == SPU_PWR_OFF) fesel_q <= pwdata[6];
            if (paddr == SPU_CFG_OFF) fast_q <= pwdata[0];
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    // Low phases of the shift clock
    sequence lo_slow;
        !serial_out_pin [*6] ##1 serial_out_pin;
    endsequence
    sequence lo_fast;
        !serial_out_pin ##1 serial_out_pin;
    endsequence

    chk_unmapped_err: assert property (acc && !mapped |-> pslverr)
        else $error("no error");
    chk_mapped_ok: assert property (acc && mapped |-> !pslverr)
        else $error("false error");
    chk_irq_sticky: assert property (port_irq && !(wr && paddr == SPU_CTRL_OFF) |=> port_irq)
        else $error("irq dropped");
    chk_pin_input: assert property (!m0 && !$past(m0) |-> serial_data_pin_oe_n)
        else $error("pin driven");
    chk_tx_start: assert property (wr && paddr == SPU_BUF_OFF && !m0 |-> ##[1:80] !serial_out_pin)
        else $error("no start bit");
    chk_clk_slow: assert property ($fell(serial_out_pin) && m0 && !fast_q |-> lo_slow)
        else $error("slow clock");
    chk_clk_fast: assert property ($fell(serial_out_pin) && m0 && fast_q |-> lo_fast)
        else $error("fast clock");
    chk_m0_done: assert property (wr && paddr == SPU_BUF_OFF && m0 && fast_q && !port_irq |-> ##[8:60] port_irq)
        else $error("no done");
    chk_reset_idle: assert property ($past(reset) && !reset |-> serial_out_pin && serial_data_pin_oe_n && !port_irq)
        else $error("not idle");
endmodule : spu_port_monitor
`default_nettype wire

// [tb/spu_peer_model.sv]
// Remote serial peer: frame sender and line decoder
`timescale 1ns/1ps
`default_nettype none
module spu_peer_model (
    // Clock
    input  wire logic       ref_clk,
    // Line from device and decoder setup
    input  wire logic       tx_line,
    input  wire logic       dec_en,
    input  wire logic [7:0] bit_cyc,
    input  wire logic       nine,
    // Line to device and decoded frame
    output logic            rx_line,
    output logic            got_v,
    output logic [8:0]      got_d
);
    logic [9:0] sh;

    // Idle high: line has a pull-up
    initial {rx_line, got_v, got_d} = 11'h400;

    // Start 0, data LSB first, ninth bit when nine, stop
    task automatic send(input logic [8:0] d, input logic stop);
        logic [10:0] f;
        f = nine ? {stop, d, 1'b0} : {1'b0, stop, d[7:0], 1'b0};
        for (int k = 0; k < (nine ? 11 : 10); k++) begin
            @(posedge ref_clk);
            rx_line <= f[k];
            repeat (bit_cyc - 1) @(posedge ref_clk);
        end
        @(posedge ref_clk);
        rx_line <= 1'b1;
    endtask : send

    // Decode from mid start bit; mode 1 reports stop in bit 8
    always begin
        @(negedge tx_line iff dec_en);
        repeat (bit_cyc / 2) @(posedge ref_clk);
        for (int i = 0; i < (nine ? 10 : 9); i++) begin
            repeat (bit_cyc) @(posedge ref_clk);
            sh = {tx_line, sh[9:1]};
        end
        @(posedge ref_clk);
        got_d <= nine ? sh[8:0] : sh[9:1];
        got_v <= 1'b1;
        @(posedge ref_clk);
        got_v <= 1'b0;
    end
endmodule : spu_peer_model
`default_nettype wire

// [tb/spu_serial_port_tb.sv]
// Bench for the serial port
`timescale 1ns/1ps
`default_nettype none
module spu_serial_port_tb
    import spu_pkg::*;
;
    logic        ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        t1_ovf = 1'b0, t2_ovf = 1'b0, dec_en = 1'b0, nine = 1'b0, sout_d = 1'b1;
    logic        pready, pslverr, pin_lvl, dout, doe_n, sout, irq, peer_line, got_v;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, seed = 32'h7969, prdata;
    logic [7:0]  bit_cyc = 8'h40, m0_sh;
    logic [1:0]  tdiv = 2'h0;
    logic [8:0]  got_d;
    logic [16:0] x;
    logic [16:0] rd_q[$];
    logic [8:0]  line_q[$];
    int          mismatches = 0, total_checks = 0, edges = 0, e0, k;
    logic [7:0]  ctls[5] = '{8'h40, 8'hc8, 8'h80, 8'h88, 8'h80};
    logic [7:0]  cfgs[5] = '{8'h00, 8'h02, 8'h08, 8'h04, 8'h00};

    spu_serial_port spu_serial_port_i (
        .ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .t1_ovf, .t2_ovf, .serial_data_pin_i(pin_lvl), .serial_data_pin_o(dout),
        .serial_data_pin_oe_n(doe_n), .serial_out_pin(sout), .port_irq(irq));
    spu_peer_model spu_peer_model_i (
        .ref_clk, .tx_line(sout), .dec_en, .bit_cyc, .nine, .rx_line(peer_line), .got_v, .got_d);

    // Shared data pin
    assign pin_lvl = doe_n ? peer_line : dout;

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    // Timer overflows every fourth cycle
    always @(posedge ref_clk) begin
        tdiv   <= tdiv + 2'h1;
        t1_ovf <= tdiv == 2'h0;
        t2_ovf <= tdiv == 2'h2;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    task automatic cmp_reg(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected read at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp_reg

    task automatic cmp_line(input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected line at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp_line

    // One transfer, then an idle edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m, input logic err);
        rd_q.push_back({err, m, e});
        apb(a, 1'b0, 8'h00);
    endtask : rd

    task automatic wait_irq();
        for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge ref_clk);
    endtask : wait_irq

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // Reads and frames against the oldest note; shift clock rises and their data
    always @(posedge ref_clk) begin
        if (psel && penable && pready && !pwrite && rd_q.size() > 0) begin
            x = rd_q.pop_front();
            cmp_reg({pslverr, prdata & {24'hffffff, x[15:8]}}, {x[16], 24'h0, x[7:0] & x[15:8]});
        end
        if (got_v === 1'b1) cmp_line(got_d, line_q.size() > 0 ? line_q.pop_front() : ~got_d);
        sout_d <= sout;
        if (sout === 1'b1 && sout_d === 1'b0) begin
            edges++;
            m0_sh <= {dout, m0_sh[7:1]};
        end
    end

    // Cut a hang short
    initial begin
        repeat (60000) @(posedge ref_clk);
        mismatches++;
        finish_test();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        // Reset values and a refused address
        rd(SPU_CTRL_OFF, SPU_CTRL_RST, 8'hff, 1'b0);
        rd(SPU_CFG_OFF, SPU_CFG_RST, 8'hff, 1'b0);
        rd(12'h020, 8'h00, 8'hff, 1'b1);
        // Transmit in modes 1 to 3, every divider and both timers
        dec_en <= 1'b1;
        for (k = 0; k < 5; k++) begin
            seed = xs(seed);
            nine <= ctls[k][7];
            bit_cyc <= 8'h40 >> cfgs[k][3:2];
            apb(SPU_CFG_OFF, 1'b1, cfgs[k]);
            apb(SPU_CTRL_OFF, 1'b1, ctls[k]);
            line_q.push_back({ctls[k][7] ? ctls[k][3] : 1'b1, seed[7:0]});
            apb(SPU_BUF_OFF, 1'b1, seed[7:0]);
            wait_irq();
            rd(SPU_CTRL_OFF, 8'h02, 8'h03, 1'b0);
            repeat (192) @(posedge ref_clk);
            apb(SPU_CTRL_OFF, 1'b1, ctls[k]);
        end
        // Mode 1 receive: disabled, then overrun
        nine <= 1'b0;
        bit_cyc <= 8'h40;
        apb(SPU_CFG_OFF, 1'b1, 8'h00);
        apb(SPU_CTRL_OFF, 1'b1, 8'h40);
        spu_peer_model_i.send(9'h0a5, 1'b1);
        repeat (128) @(posedge ref_clk);
        rd(SPU_CTRL_OFF, 8'h00, 8'h01, 1'b0);
        apb(SPU_CTRL_OFF, 1'b1, 8'h50);
        for (k = 0; k < 2; k++) begin
            seed = xs(seed);
            spu_peer_model_i.send({1'b0, seed[7:0]}, 1'b1);
        end
        repeat (128) @(posedge ref_clk);
        rd(SPU_CTRL_OFF, 8'h55, 8'hff, 1'b0);
        rd(SPU_BUF_OFF, seed[7:0], 8'hff, 1'b0);
        rd(SPU_STAT_OFF, 8'h08, 8'h08, 1'b0);
        // Missing stop bit, shared bit 7
        apb(SPU_PWR_OFF, 1'b1, 8'h40);
        apb(SPU_CTRL_OFF, 1'b1, 8'h50);
        spu_peer_model_i.send(9'h03c, 1'b0);
        repeat (128) @(posedge ref_clk);
        rd(SPU_CTRL_OFF, 8'h80, 8'h80, 1'b0);
        apb(SPU_PWR_OFF, 1'b1, 8'h00);
        rd(SPU_CTRL_OFF, 8'h00, 8'h80, 1'b0);
        apb(SPU_PWR_OFF, 1'b1, 8'h40);
        rd(SPU_CTRL_OFF, 8'h80, 8'h80, 1'b0);
        apb(SPU_CTRL_OFF, 1'b1, 8'h50);
        rd(SPU_CTRL_OFF, 8'h00, 8'h80, 1'b0);
        apb(SPU_PWR_OFF, 1'b1, 8'h00);
        // Mode 3 filter: data dropped, address kept
        nine <= 1'b1;
        apb(SPU_CTRL_OFF, 1'b1, 8'hf0);
        spu_peer_model_i.send(9'h011, 1'b1);
        repeat (128) @(posedge ref_clk);
        rd(SPU_CTRL_OFF, 8'h00, 8'h01, 1'b0);
        spu_peer_model_i.send(9'h1c3, 1'b1);
        repeat (128) @(posedge ref_clk);
        rd(SPU_CTRL_OFF, 8'h05, 8'h05, 1'b0);
        rd(SPU_BUF_OFF, 8'hc3, 8'hff, 1'b0);
        // Mode 0: both rates, then a receive
        dec_en <= 1'b0;
        apb(SPU_CTRL_OFF, 1'b1, 8'h00);
        for (k = 0; k < 2; k++) begin
            apb(SPU_CFG_OFF, 1'b1, {7'h00, ~k[0]});
            e0 = edges;
            apb(SPU_BUF_OFF, 1'b1, 8'h96);
            wait_irq();
            repeat (20) @(posedge ref_clk);
            cmp_line(9'(edges - e0), 9'h008);
            cmp_line({1'b0, m0_sh}, 9'h096);
            rd(SPU_CTRL_OFF, 8'h02, 8'hff, 1'b0);
            apb(SPU_CTRL_OFF, 1'b1, 8'h00);
        end
        apb(SPU_CTRL_OFF, 1'b1, 8'h30);
        wait_irq();
        repeat (20) @(posedge ref_clk);
        rd(SPU_CTRL_OFF, 8'h31, 8'hf3, 1'b0);
        rd(SPU_BUF_OFF, 8'hff, 8'hff, 1'b0);
        cmp_line(9'(line_q.size()), 9'h000);
        finish_test();
    end
endmodule : spu_serial_port_tb

bind spu_serial_port spu_port_monitor spu_port_monitor_i (
    .ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .serial_data_pin_oe_n, .serial_out_pin, .port_irq);
`default_nettype wire
